// ==== src/serial_mem_defs.svh ====
// Constants for the two-wire serial byte memory target
`ifndef SERIAL_MEM_DEFS_SVH
`define SERIAL_MEM_DEFS_SVH
`define MEM_DEPTH      512
`define ADDR_W         9
`define PAGE_BYTES     256
// Device-type code; value is arbitrary
`define TYPE_CODE      4'h6
`define BIT_LAST       3'h7
`define ADDR_TOP       9'h1ff
`define ADDR_ZERO      9'h000
`define ADDR_ONE       9'h001
`define CNT_ZERO       3'h0
`define CNT_ONE        3'h1
`define SA_TYPE_HI     7
`define SA_TYPE_LO     4
`define SA_SEL_HI      3
`define SA_SEL_LO      2
`define SA_PAGE        1
`define SA_RW          0
`define WORD_HI        7
`define BYTE_MSB       7
`define BELOW_MSB      6
`endif

// ==== src/serial_mem_pkg.sv ====
// Types for the two-wire serial byte memory target
package serial_mem_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SLAVE, ST_WORD, ST_WDATA, ST_RDATA, ST_ACK_OUT, ST_ACK_IN
   } phase_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } bus_pins_t;
endpackage : serial_mem_pkg

// ==== src/serial_mem_target.sv ====
// Two-wire serial 512-byte memory target, oversampled on clk
`timescale 1ns/1ps
`include "serial_mem_defs.svh"
module serial_mem_target
   import serial_mem_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Two-wire bus
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // Straps
   input  wire logic [1:0] device_select_pins,
   input  wire logic       write_protect
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; first stage read only by the second
   bus_pins_t   meta_r, sync_r, prev_r;
   bus_pins_t   meta_nxt, sync_nxt, prev_nxt;
   logic [1:0]  sel_meta_r, sel_sync_r;
   logic [1:0]  sel_meta_nxt, sel_sync_nxt;
   logic        wp_meta_r, wp_sync_r;
   logic        wp_meta_nxt, wp_sync_nxt;

   always_comb begin
      meta_nxt     = '{scl: scl_in, sda: sda_in};
      sync_nxt     = meta_r;
      prev_nxt     = sync_r;
      sel_meta_nxt = device_select_pins;
      sel_sync_nxt = sel_meta_r;
      wp_meta_nxt  = write_protect;
      wp_sync_nxt  = wp_meta_r;
   end

   // Reset to idle bus level, so no false edge follows reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r     <= '{scl: 1'b1, sda: 1'b1};
         sync_r     <= '{scl: 1'b1, sda: 1'b1};
         prev_r     <= '{scl: 1'b1, sda: 1'b1};
         sel_meta_r <= 2'h0;
         sel_sync_r <= 2'h0;
         wp_meta_r  <= 1'b0;
         wp_sync_r  <= 1'b0;
      end else begin
         meta_r     <= meta_nxt;
         sync_r     <= sync_nxt;
         prev_r     <= prev_nxt;
         sel_meta_r <= sel_meta_nxt;
         sel_sync_r <= sel_sync_nxt;
         wp_meta_r  <= wp_meta_nxt;
         wp_sync_r  <= wp_sync_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus edges and conditions
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise  = sync_r.scl & ~prev_r.scl;
   assign scl_fall  = ~sync_r.scl & prev_r.scl;
   assign start_det = sync_r.scl & prev_r.scl & prev_r.sda & ~sync_r.sda;
   assign stop_det  = sync_r.scl & prev_r.scl & ~prev_r.sda & sync_r.sda;

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   // two pages of 256 bytes
   logic [7:0] mem_r [0:`MEM_DEPTH-1];

   ////////////////////////////////////////////////////////////////////////////
   // Protocol state
   phase_t               phase_r, phase_nxt;
   phase_t               after_r, after_nxt;
   logic [2:0]           cnt_r, cnt_nxt;
   logic [7:0]           shift_r, shift_nxt;
   logic [`ADDR_W-1:0]   addr_r, addr_nxt;
   logic                 page_ld, word_ld, addr_inc;
   logic [7:0]           mem_rd;
   logic                 ack_drive_r, ack_drive_nxt;
   logic                 sda_drv_r, sda_drv_nxt;
   logic                 wr_en;
   logic [7:0]           byte_in;
   logic                 addr_hit;

   assign byte_in  = {shift_r[6:0], sync_r.sda};
   assign addr_hit = (byte_in[`SA_TYPE_HI:`SA_TYPE_LO] == `TYPE_CODE) &&
                     (byte_in[`SA_SEL_HI:`SA_SEL_LO] == sel_sync_r);
   // read data from the latched address
   assign mem_rd   = mem_r[addr_r];

   always_comb begin
      phase_nxt     = phase_r;
      after_nxt     = after_r;
      cnt_nxt       = cnt_r;
      shift_nxt     = shift_r;
      page_ld       = 1'b0;
      word_ld       = 1'b0;
      addr_inc      = 1'b0;
      ack_drive_nxt = ack_drive_r;
      sda_drv_nxt   = sda_drv_r;
      wr_en         = 1'b0;
      if (start_det) begin
         phase_nxt   = ST_SLAVE;
         cnt_nxt     = `CNT_ZERO;
         sda_drv_nxt = 1'b0;
      end else if (stop_det) begin
         phase_nxt   = ST_IDLE;
         sda_drv_nxt = 1'b0;
      end else if (scl_rise) begin
         case (phase_r)
            ST_SLAVE, ST_WORD, ST_WDATA: begin
               shift_nxt = byte_in;
               cnt_nxt   = cnt_r + `CNT_ONE;
               if (cnt_r == `BIT_LAST) begin
                  ack_drive_nxt = 1'b0;
                  after_nxt     = ST_IDLE;
                  if (phase_r == ST_SLAVE) begin
                     if (addr_hit) begin
                        page_ld       = 1'b1;
                        ack_drive_nxt = 1'b1;
                        after_nxt     = byte_in[`SA_RW] ? ST_RDATA : ST_WORD;
                     end
                  end else if (phase_r == ST_WORD) begin
                     word_ld       = 1'b1;
                     ack_drive_nxt = 1'b1;
                     after_nxt     = ST_WDATA;
                  end else if (!wp_sync_r) begin
                     wr_en         = 1'b1;
                     addr_inc      = 1'b1;
                     ack_drive_nxt = 1'b1;
                     after_nxt     = ST_WDATA;
                  end
                  // protected byte: no ack, address held
                  phase_nxt = ST_ACK_OUT;
               end
            end
            ST_RDATA: begin
               cnt_nxt = cnt_r + `CNT_ONE;
               if (cnt_r == `BIT_LAST) begin
                  addr_inc  = 1'b1;
                  phase_nxt = ST_ACK_IN;
               end
            end
            ST_ACK_IN: begin
               // continue on ack, end on no-ack
               phase_nxt = sync_r.sda ? ST_IDLE : ST_RDATA;
            end
            default: ;
         endcase
      end else if (scl_fall) begin
         case (phase_r)
            ST_ACK_OUT: begin
               if (ack_drive_r) begin
                  sda_drv_nxt   = 1'b1;
                  ack_drive_nxt = 1'b0;
               end else begin
                  sda_drv_nxt = 1'b0;
                  cnt_nxt     = `CNT_ZERO;
                  phase_nxt   = after_r;
                  if (after_r == ST_RDATA) begin
                     shift_nxt   = {mem_rd[`BELOW_MSB:0], 1'b0};
                     sda_drv_nxt = ~mem_rd[`BYTE_MSB];
                  end
               end
            end
            ST_RDATA: begin
               if (cnt_r == `CNT_ZERO) begin
                  // next sequential byte after master acknowledge
                  shift_nxt   = {mem_rd[`BELOW_MSB:0], 1'b0};
                  sda_drv_nxt = ~mem_rd[`BYTE_MSB];
               end else begin
                  shift_nxt   = {shift_r[`BELOW_MSB:0], 1'b0};
                  sda_drv_nxt = ~shift_r[`BYTE_MSB];
               end
            end
            ST_ACK_IN: begin
               sda_drv_nxt = 1'b0;
            end
            default: sda_drv_nxt = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address latch; strobes from the protocol logic, one at a time
   always_comb begin
      addr_nxt = addr_r;
      if (page_ld) begin
         // page bit is the address MSB
         addr_nxt[`ADDR_W-1] = byte_in[`SA_PAGE];
      end else if (word_ld) begin
         // word byte fills the low bits
         addr_nxt[`WORD_HI:0] = byte_in;
      end else if (addr_inc) begin
         addr_nxt = (addr_r == `ADDR_TOP) ? `ADDR_ZERO : addr_r + `ADDR_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         addr_r <= `ADDR_ZERO;
      end else begin
         addr_r <= addr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers; no busy state, any phase leads straight back
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_r     <= ST_IDLE;
         after_r     <= ST_IDLE;
         cnt_r       <= `CNT_ZERO;
         shift_r     <= 8'h00;
         ack_drive_r <= 1'b0;
         sda_drv_r   <= 1'b0;
      end else begin
         phase_r     <= phase_nxt;
         after_r     <= after_nxt;
         cnt_r       <= cnt_nxt;
         shift_r     <= shift_nxt;
         ack_drive_r <= ack_drive_nxt;
         sda_drv_r   <= sda_drv_nxt;
      end
   end

   // Array is not reset; contents are nonvolatile in spirit
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[addr_r] <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain data pin; only data is ever driven, never the clock
   logic oe_n_r, oe_n_nxt;

   // Enable straight from a flop, no gate between flop and pin
   always_comb begin
      oe_n_nxt = ~sda_drv_nxt;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         oe_n_r <= 1'b1;
      end else begin
         oe_n_r <= oe_n_nxt;
      end
   end

   assign sda_out  = 1'b0;
   assign sda_oe_n = oe_n_r;

endmodule : serial_mem_target

// ==== verification/bus_master_model.sv ====
// Two-wire bus master model, 400 ns bus clock
`timescale 1ns/1ps
module bus_master_model (
   // Clock
   input  wire logic clk,
   // Bus
   output logic      scl,
   output logic      sda_drv,
   input  wire logic sda
);
   initial begin
      scl     = 1'h1;
      sda_drv = 1'h1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   // data moves only with clock low; caller sends MSB first
   task automatic bit_x(input logic b, output logic s);
      scl = 1'h0;
      wt(2);
      sda_drv = b;
      wt(2);
      scl = 1'h1;
      wt(3);
      s = sda;
      wt(1);
   endtask : bit_x
   task automatic cond(input logic a, input logic b);
      scl = 1'h0;
      wt(2);
      sda_drv = a;
      wt(2);
      scl = 1'h1;
      wt(4);
      sda_drv = b;
      wt(4);
   endtask : cond
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(d[i], s);
      bit_x(1'h1, ack);
   endtask : put_byte
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(1'h1, d[i]);
      // no acknowledge on the last byte
      bit_x(nack, s);
   endtask : get_byte
endmodule : bus_master_model

// ==== verification/serial_mem_target_checker.sv ====
// Bus timing checks on the memory target ports
`timescale 1ns/1ps
module serial_mem_target_checker (
   // Clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // Bus
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   // Straps
   input wire logic [1:0] device_select_pins,
   input wire logic       write_protect
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   sequence s_start;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence s_stop;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   property p_rst_rel;
      $fell(sys_rst) |-> sda_oe_n;
   endproperty
   a_rst_rel: assert property (p_rst_rel) else $error("driving after reset");
   property p_out_zero;
      sda_out == 1'h0;
   endproperty
   a_out_zero: assert property (p_out_zero) else $error("data value not low");
   // Clock high twice: output must hold
   property p_stable_high;
      scl_in && $past(scl_in, 2) |-> $stable(sda_oe_n);
   endproperty
   a_stable_high: assert property (p_stable_high) else $error("moved in clock high");
   property p_ack_hold;
      $fell(sda_oe_n) |=> !sda_oe_n [*4];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("drive too short");
   property p_start_rel;
      s_start |=> sda_oe_n [*8];
   endproperty
   a_start_rel: assert property (p_start_rel) else $error("drive after start");
   property p_stop_rel;
      s_stop |=> sda_oe_n [*8];
   endproperty
   a_stop_rel: assert property (p_stop_rel) else $error("drive after stop");
   property p_fall_follows;
      $changed(sda_oe_n) |-> !$past(scl_in, 2) && $past(scl_in, 6);
   endproperty
   a_fall_follows: assert property (p_fall_follows) else $error("change not after fall");
   property p_release_holds;
      $rose(sda_oe_n) |=> sda_oe_n [*4];
   endproperty
   a_release_holds: assert property (p_release_holds) else $error("release too short");
endmodule : serial_mem_target_checker
bind serial_mem_target serial_mem_target_checker i_chk (.clk(clk), .sys_rst(sys_rst),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .device_select_pins(device_select_pins), .write_protect(write_protect));

// ==== verification/test_serial_mem_target.sv ====
// Self-checking bench for the memory target
`timescale 1ns/1ps
`include "serial_mem_defs.svh"
module test_serial_mem_target;
   logic       clk, sys_rst, scl, sda_drv, sda_out, sda_oe_n, write_protect, ak;
   logic [1:0] device_select_pins;
   logic [7:0] rd;
   wire logic  sda;
   int         fail_count, tests_run;
   // Pull-up wire: low if either party pulls
   assign sda = sda_drv & (sda_oe_n ? 1'h1 : sda_out);
   serial_mem_target i_serial_mem_target (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .device_select_pins(device_select_pins), .write_protect(write_protect));
   bus_master_model mst (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
   always #25 clk = ~clk;
   ////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   function automatic logic [7:0] sa(input logic pg, input logic rw);
      return {`TYPE_CODE, 2'h2, pg, rw};
   endfunction : sa
   task automatic send(input logic [7:0] d, input logic e, input string nm);
      mst.put_byte(d, ak);
      check(nm, {7'h00, ak}, {7'h00, e});
   endtask : send
   task automatic recv(input logic nack, input logic [7:0] e, input string nm);
      mst.get_byte(nack, rd);
      check(nm, rd, e);
   endtask : recv
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   initial begin
      clk = 1'h0;
      sys_rst = 1'h1;
      write_protect = 1'h0;
      device_select_pins = 2'h2;
      fail_count = 0;
      tests_run = 0;
      repeat (3) @(negedge clk);
      sys_rst = 1'h0;
      repeat (5) @(negedge clk);
      mst.cond(1'h1, 1'h0);
      send(sa(1'h1, 1'h0), 1'h0, "slave");
      send(8'hfe, 1'h0, "word");
      send(8'ha5, 1'h0, "data0");
      send(8'h3c, 1'h0, "data1");
      send(8'h5a, 1'h0, "data2");
      mst.cond(1'h0, 1'h1);
      $display("test write wrap done");
      mst.cond(1'h1, 1'h0);
      send(sa(1'h1, 1'h0), 1'h0, "rslave");
      send(8'hfe, 1'h0, "rword");
      mst.cond(1'h1, 1'h0);
      send(sa(1'h1, 1'h1), 1'h0, "rdslave");
      recv(1'h0, 8'ha5, "rd0");
      recv(1'h0, 8'h3c, "rd1");
      recv(1'h1, 8'h5a, "rd2");
      mst.cond(1'h0, 1'h1);
      $display("test read wrap done");
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h0) ^ 8'h10, 1'h1, "badtype");
      mst.cond(1'h0, 1'h1);
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h0) ^ 8'h04, 1'h1, "badsel");
      mst.cond(1'h0, 1'h1);
      $display("test mismatch done");
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h0), 1'h0, "wslave");
      send(8'h10, 1'h0, "wword");
      send(8'h77, 1'h0, "wdata");
      mst.cond(1'h0, 1'h1);
      write_protect = 1'h1;
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h0), 1'h0, "pslave");
      send(8'h10, 1'h0, "pword");
      send(8'h11, 1'h1, "pdata");
      mst.cond(1'h0, 1'h1);
      write_protect = 1'h0;
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h1), 1'h0, "pread");
      recv(1'h1, 8'h77, "pkept");
      mst.cond(1'h0, 1'h1);
      $display("test protect done");
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h0), 1'h0, "aslave");
      send(8'h10, 1'h0, "aword");
      repeat (4) mst.bit_x(1'h0, ak);
      mst.cond(1'h0, 1'h1);
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h0), 1'h0, "bslave");
      send(8'h10, 1'h0, "bword");
      mst.cond(1'h1, 1'h0);
      send(sa(1'h0, 1'h1), 1'h0, "bread");
      recv(1'h1, 8'h77, "akept");
      mst.cond(1'h0, 1'h1);
      $display("test abort done");
      test_done;
   end
   // Whole run is near 2200 cycles
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      test_done;
   end
endmodule : test_serial_mem_target
